// >>> epp_pkg.sv
`default_nettype none
// ==========================================================================
// Shared constants for the parallel port handshake block
package epp_pkg;
  // ========================================================================
  // Clock and timing
  localparam int CLK_MHZ      = 100;
  localparam int SETTLE_NS    = 50;    // Least quiet time before a line counts
  localparam int SETTLE_CYC   = (SETTLE_NS * CLK_MHZ + 999) / 1000;
  localparam int TOUT_US      = 10;    // Least time before a cycle is aborted
  localparam int TOUT_CYC     = TOUT_US * CLK_MHZ;
  localparam int FIFO_STB_NS  = 500;   // Least strobe width in forward FIFO mode
  localparam int FIFO_STB_CYC = (FIFO_STB_NS * CLK_MHZ + 999) / 1000;

  // ========================================================================
  // Counter widths and typed counts
  localparam int SET_W = 3;
  localparam int TOUT_W = 11;
  localparam int STB_W = 7;
  localparam logic [SET_W-1:0]  SETTLE_LAST = SET_W'(SETTLE_CYC - 1);
  localparam logic [TOUT_W-1:0] TOUT_CNT    = TOUT_W'(TOUT_CYC);
  localparam logic [STB_W-1:0]  FIFO_STB_CNT = STB_W'(FIFO_STB_CYC - 1);

  // ========================================================================
  // Filtered cable lines and mode codes
  localparam int          LINES     = 2;
  localparam int          LINE_WAIT = 0;
  localparam int          LINE_BUSY = 1;
  localparam logic [1:0]  LINE_RST  = 2'h1;  // Wait resets high as if done, busy low
  localparam logic [2:0]  MODE_FIFO = 3'h5;
  localparam logic [7:0]  DATA_RST  = 8'h00;

  // ========================================================================
  // Transfer sequencer states
  typedef enum logic [2:0] {
    EPP_IDLE,
    EPP_SETUP,
    EPP_WAITRDY,
    EPP_STROBE,
    EPP_DONE,
    EPP_F_IDLE,
    EPP_F_SETUP,
    EPP_F_STB
  } epp_state_e;
endpackage
`default_nettype wire

// >>> epp_sig_if.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================================
// Carrier between the sequencer, the line filter and the timeout timer
interface epp_sig_if;
  import epp_pkg::*;
  logic [LINES-1:0] line_raw;
  logic [LINES-1:0] line_settled;
  logic             timer_run;
  logic             timer_expired;

  modport filt (input line_raw, output line_settled);
  modport tmr  (input timer_run, output timer_expired);
  modport core (output line_raw, input line_settled, output timer_run, input timer_expired);
endinterface
`default_nettype wire

// >>> epp_line_filter.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================================
// Two-flop synchroniser plus settle filter for the cable status lines
module epp_line_filter
(
  input  wire logic clock_in,
  input  wire logic rst_n_in,
  epp_sig_if.filt   sig
);
  import epp_pkg::*;

  logic [LINES-1:0] meta_r;
  logic [LINES-1:0] sync_r;
  logic [LINES-1:0] settled_r;
  logic [LINES-1:0] settled_nxt;
  logic [SET_W-1:0] cnt_r   [LINES];
  logic [SET_W-1:0] cnt_nxt [LINES];

  // A line only moves once it stayed put long enough; ringing resets the count
  always_comb
  begin
    settled_nxt = settled_r;
    for (int i = 0; i < LINES; i++)
    begin
      cnt_nxt[i] = '0;
      if (sync_r[i] != settled_r[i])
      begin
        if (cnt_r[i] == SETTLE_LAST)
        begin
          settled_nxt[i] = sync_r[i];
        end
        else
        begin
          cnt_nxt[i] = cnt_r[i] + SET_W'(1);
        end
      end
    end
  end

  // Registers; the first flop feeds only the second
  always_ff @(posedge clock_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      meta_r    <= LINE_RST;
      sync_r    <= LINE_RST;
      settled_r <= LINE_RST;
      for (int i = 0; i < LINES; i++)
      begin
        cnt_r[i] <= '0;
      end
    end
    else
    begin
      meta_r    <= sig.line_raw;
      sync_r    <= meta_r;
      settled_r <= settled_nxt;
      for (int i = 0; i < LINES; i++)
      begin
        cnt_r[i] <= cnt_nxt[i];
      end
    end
  end

  assign sig.line_settled = settled_r;

  // Wait only moves after a full quiet run of the synchronised level
  AST_WAIT_SETTLE: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    $changed(settled_r[LINE_WAIT]) |->
      $past(cnt_r[LINE_WAIT]) == SETTLE_LAST && $past(sync_r[LINE_WAIT]) == settled_r[LINE_WAIT])
    else $error("wait line settled without quiet period");
endmodule
`default_nettype wire

// >>> epp_timeout.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================================
// Handshake timeout timer, restarts whenever run drops
module epp_timeout
(
  input  wire logic clock_in,
  input  wire logic rst_n_in,
  epp_sig_if.tmr    sig
);
  import epp_pkg::*;

  logic [TOUT_W-1:0] cnt_r;
  logic [TOUT_W-1:0] cnt_nxt;

  // Saturates at the limit so expiry stays up until the sequencer reacts
  always_comb
  begin
    cnt_nxt = '0;
    if (sig.timer_run)
    begin
      cnt_nxt = (cnt_r == TOUT_CNT) ? cnt_r : cnt_r + TOUT_W'(1);
    end
  end

  // Count register
  always_ff @(posedge clock_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      cnt_r <= '0;
    end
    else
    begin
      cnt_r <= cnt_nxt;
    end
  end

  assign sig.timer_expired = (cnt_r == TOUT_CNT);

  // Expiry comes only from a run that reached the full count
  AST_TOUT_EXPIRE: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    $rose(sig.timer_expired) |-> $past(sig.timer_run) && $past(cnt_r) == TOUT_CNT - TOUT_W'(1))
    else $error("timeout expired early");
endmodule
`default_nettype wire

// >>> epp_parallel_port_handshake.sv
`timescale 1ns/1ps
`default_nettype none
module epp_parallel_port_handshake
(
  input  wire logic       clock_in,
  input  wire logic       rst_n_in,
  // Host side, from on-chip address decode on this clock
  input  wire logic       host_req_in,
  input  wire logic       host_write_in,
  input  wire logic       host_addr_cycle_in,
  input  wire logic [7:0] host_system_data_in,
  output logic      [7:0] host_system_data_out,
  output logic            chan_ready_out,
  // Configuration and status
  input  wire logic [2:0] port_mode_in,
  input  wire logic       epp_v19_in,
  input  wire logic       port_direction_bit_in,
  input  wire logic       timeout_clr_in,
  output logic            timeout_flag_out,
  // Forward DMA feed
  output logic            dma_req_out,
  input  wire logic       dma_ack_in,
  input  wire logic [7:0] dma_data_in,
  // Cable
  input  wire logic [7:0] cable_data_lines_in,
  output logic      [7:0] cable_data_lines_out,
  output logic            cable_data_oe_n_out,
  output logic            transfer_direction_n_out,
  output logic            data_strobe_n_out,
  output logic            addr_strobe_n_out,
  output logic            host_strobe_n_out,
  input  wire logic       peripheral_wait_n_in,
  input  wire logic       peripheral_busy_in
);
  import epp_pkg::*;

  // ========================================================================
  // Submodules
  epp_sig_if sig ();

  epp_line_filter u_filter
  (
    .clock_in (clock_in),
    .rst_n_in (rst_n_in),
    .sig      (sig.filt)
  );

  epp_timeout u_timeout
  (
    .clock_in (clock_in),
    .rst_n_in (rst_n_in),
    .sig      (sig.tmr)
  );

  // ========================================================================
  // State
  epp_state_e       state_r,   state_nxt;
  logic             wr_r,      wr_nxt;
  logic             addr_r,    addr_nxt;
  logic             dir_n_r,   dir_n_nxt;
  logic             dstb_n_r,  dstb_n_nxt;
  logic             astb_n_r,  astb_n_nxt;
  logic             fstb_n_r,  fstb_n_nxt;
  logic             oe_n_r,    oe_n_nxt;
  logic             rdy_r,     rdy_nxt;
  logic             tout_r,    tout_nxt;
  logic [7:0]       dout_r,    dout_nxt;
  logic [7:0]       rdata_r,   rdata_nxt;
  logic [STB_W-1:0] scnt_r,    scnt_nxt;
  logic [7:0]       dmeta_r;
  logic [7:0]       dsync_r;
  logic             wait_n;
  logic             busy;
  logic             fifo_mode;
  logic             epp_start;
  logic             epp_strobe_n;

  // Raw cable lines go through the filter; read data gets its own two flops
  assign sig.line_raw[LINE_WAIT] = peripheral_wait_n_in;
  assign sig.line_raw[LINE_BUSY] = peripheral_busy_in;
  assign wait_n    = sig.line_settled[LINE_WAIT];
  assign busy      = sig.line_settled[LINE_BUSY];
  assign fifo_mode = (port_mode_in == MODE_FIFO);
  assign epp_start = (state_r == EPP_IDLE) && host_req_in && !fifo_mode;
  assign epp_strobe_n = dstb_n_r & astb_n_r;
  assign sig.timer_run = (state_r == EPP_WAITRDY) || (state_r == EPP_STROBE);

  // Direction line: 1.9 owns it per cycle, 1.7 follows the software bit
  function automatic logic dir_level(input logic v19, input logic writing);
    dir_level = v19 ? !writing : port_direction_bit_in;
  endfunction

  // ========================================================================
  // Next-state logic of the transfer sequencer
  always_comb
  begin
    state_nxt  = state_r;
    wr_nxt     = wr_r;
    addr_nxt   = addr_r;
    dir_n_nxt  = dir_level(epp_v19_in, 1'b0);
    dstb_n_nxt = dstb_n_r;
    astb_n_nxt = astb_n_r;
    fstb_n_nxt = fstb_n_r;
    oe_n_nxt   = oe_n_r;
    rdy_nxt    = rdy_r;
    dout_nxt   = dout_r;
    rdata_nxt  = rdata_r;
    scnt_nxt   = scnt_r;
    // Set wins over clear so a timeout in the clearing cycle is kept
    tout_nxt   = timeout_clr_in ? 1'b0 : tout_r;
    case (state_r)
      EPP_IDLE:
      begin
        rdy_nxt  = 1'b1;
        oe_n_nxt = 1'b0;
        if (fifo_mode)
        begin
          state_nxt = EPP_F_IDLE;
        end
        else if (host_req_in)
        begin
          // Stretch the host cycle from the first edge on
          rdy_nxt   = 1'b0;
          wr_nxt    = host_write_in;
          addr_nxt  = host_addr_cycle_in;
          dir_n_nxt = dir_level(epp_v19_in, host_write_in);
          if (host_write_in)
          begin
            dout_nxt = host_system_data_in;
          end
          else
          begin
            oe_n_nxt = 1'b1;
          end
          state_nxt = EPP_SETUP;
        end
      end
      EPP_SETUP:
      begin
        dir_n_nxt = dir_n_r;
        // Direction and data were set a cycle ago; strobe may now follow
        if (epp_v19_in)
        begin
          state_nxt = EPP_WAITRDY;
        end
        else
        begin
          dstb_n_nxt = addr_r;
          astb_n_nxt = !addr_r;
          state_nxt  = EPP_STROBE;
        end
      end
      EPP_WAITRDY:
      begin
        dir_n_nxt = dir_n_r;
        if (sig.timer_expired)
        begin
          tout_nxt  = 1'b1;
          state_nxt = EPP_DONE;
        end
        else if (!wait_n)
        begin
          dstb_n_nxt = addr_r;
          astb_n_nxt = !addr_r;
          state_nxt  = EPP_STROBE;
        end
      end
      EPP_STROBE:
      begin
        dir_n_nxt = dir_n_r;
        if (wait_n)
        begin
          // Peripheral has answered: end both sides of the cycle
          dstb_n_nxt = 1'b1;
          astb_n_nxt = 1'b1;
          rdy_nxt    = 1'b1;
          if (!wr_r)
          begin
            rdata_nxt = dsync_r;
          end
          state_nxt = EPP_DONE;
        end
        else if (sig.timer_expired)
        begin
          dstb_n_nxt = 1'b1;
          astb_n_nxt = 1'b1;
          tout_nxt   = 1'b1;
          state_nxt  = EPP_DONE;
        end
      end
      EPP_DONE:
      begin
        // Host must drop its request before a new cycle is taken
        dstb_n_nxt = 1'b1;
        astb_n_nxt = 1'b1;
        rdy_nxt    = 1'b1;
        if (!host_req_in)
        begin
          state_nxt = EPP_IDLE;
        end
        else
        begin
          dir_n_nxt = dir_n_r;
        end
      end
      EPP_F_IDLE:
      begin
        oe_n_nxt = 1'b0;
        if (!fifo_mode)
        begin
          state_nxt = EPP_IDLE;
        end
        else if (dma_ack_in && !busy)
        begin
          // Old byte stays on the lines until busy has dropped
          dout_nxt  = dma_data_in;
          state_nxt = EPP_F_SETUP;
        end
      end
      EPP_F_SETUP:
      begin
        fstb_n_nxt = 1'b0;
        scnt_nxt   = FIFO_STB_CNT;
        state_nxt  = EPP_F_STB;
      end
      EPP_F_STB:
      begin
        // Acknowledge is never looked at; the strobe count runs out first, then busy paces the stream
        if (scnt_r != '0)
        begin
          scnt_nxt = scnt_r - STB_W'(1);
        end
        else if (busy)
        begin
          fstb_n_nxt = 1'b1;
          state_nxt  = EPP_F_IDLE;
        end
      end
      default:
      begin
        state_nxt = EPP_IDLE;
      end
    endcase
  end

  // ========================================================================
  // Registers of the sequencer and read data synchroniser
  always_ff @(posedge clock_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      state_r  <= EPP_IDLE;
      wr_r     <= 1'b0;
      addr_r   <= 1'b0;
      dir_n_r  <= 1'b1;
      dstb_n_r <= 1'b1;
      astb_n_r <= 1'b1;
      fstb_n_r <= 1'b1;
      oe_n_r   <= 1'b1;
      rdy_r    <= 1'b1;
      tout_r   <= 1'b0;
      dout_r   <= DATA_RST;
      rdata_r  <= DATA_RST;
      scnt_r   <= '0;
      dmeta_r  <= DATA_RST;
      dsync_r  <= DATA_RST;
    end
    else
    begin
      state_r  <= state_nxt;
      wr_r     <= wr_nxt;
      addr_r   <= addr_nxt;
      dir_n_r  <= dir_n_nxt;
      dstb_n_r <= dstb_n_nxt;
      astb_n_r <= astb_n_nxt;
      fstb_n_r <= fstb_n_nxt;
      oe_n_r   <= oe_n_nxt;
      rdy_r    <= rdy_nxt;
      tout_r   <= tout_nxt;
      dout_r   <= dout_nxt;
      rdata_r  <= rdata_nxt;
      scnt_r   <= scnt_nxt;
      dmeta_r  <= cable_data_lines_in;
      dsync_r  <= dmeta_r;
    end
  end

  // ========================================================================
  // Outputs; channel ready drops combinationally in the request cycle
  assign chan_ready_out           = rdy_r && !epp_start;
  assign dma_req_out              = (state_r == EPP_F_IDLE) && fifo_mode && !busy;
  assign host_system_data_out     = rdata_r;
  assign timeout_flag_out         = tout_r;
  assign cable_data_lines_out     = dout_r;
  assign cable_data_oe_n_out      = oe_n_r;
  assign transfer_direction_n_out = dir_n_r;
  assign data_strobe_n_out        = dstb_n_r;
  assign addr_strobe_n_out        = astb_n_r;
  assign host_strobe_n_out        = fstb_n_r;

  // ========================================================================
  // Checks
  AST_DIR_BEFORE_STB: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    $fell(epp_strobe_n) && wr_r && epp_v19_in |-> !dir_n_r && !$past(dir_n_r))
    else $error("write strobe without direction low first");

  AST_DATA_BEFORE_STB: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    $fell(epp_strobe_n) && wr_r |-> !oe_n_r && $stable(dout_r))
    else $error("write data not stable at strobe");

  AST_V19_READY: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    $fell(epp_strobe_n) && epp_v19_in |-> $past(!wait_n))
    else $error("1.9 strobe before wait asserted");

  AST_STB_RELEASE: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    state_r == EPP_STROBE && wait_n |=> epp_strobe_n && rdy_r)
    else $error("strobe or ready not released on wait");

  AST_READY_LOW: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    epp_start |-> !chan_ready_out ##1 !chan_ready_out)
    else $error("channel ready not stretched");

  AST_READY_AFTER_WAIT: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    $rose(rdy_r) |-> $past(wait_n) || tout_r)
    else $error("channel ready released before wait");

  AST_READ_FLOAT: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    $fell(epp_strobe_n) && !wr_r |-> oe_n_r && $past(oe_n_r))
    else $error("read strobe with drivers on");

  AST_READ_CAPTURE: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    state_r == EPP_STROBE && !wr_r && wait_n |=> host_system_data_out == $past(dsync_r))
    else $error("read byte not passed to host");

  AST_DIR_IDLE: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    epp_v19_in && $past(epp_v19_in) && state_r == EPP_IDLE |-> dir_n_r)
    else $error("direction low outside write");

  AST_FIFO_PACE: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    $fell(fstb_n_r) |-> $past(dma_req_out && dma_ack_in, 2))
    else $error("forward strobe without DMA byte");

  AST_FIFO_HOLD: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    state_r == EPP_F_STB |=> $stable(dout_r))
    else $error("forward data changed while busy");

  AST_TOUT_FLAG: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    $rose(tout_r) |-> $past(sig.timer_expired) ##1 (tout_r || $past(timeout_clr_in)))
    else $error("timeout flag without expiry");
endmodule
`default_nettype wire

// >>> epp_periph_model.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================================
// Cable peripheral: interlocked wait handshake and busy pacing
module epp_periph_model
(
  input  wire logic       clock_in,
  input  wire logic       data_strobe_n_in,
  input  wire logic       addr_strobe_n_in,
  input  wire logic       host_strobe_n_in,
  input  wire logic       transfer_direction_n_in,
  input  wire logic       cable_data_oe_n_in,
  input  wire logic [7:0] wire_data_in,
  input  wire logic [7:0] read_byte_in,
  input  wire logic [7:0] delay_in,
  input  wire logic       mute_in,
  input  wire logic       hold_wait_in,
  output logic            peripheral_wait_n_out,
  output logic            peripheral_busy_out,
  output logic      [7:0] drive_data_out,
  output logic      [7:0] got_byte_out,
  output logic            got_addr_out,
  output logic            got_dir_n_out,
  output logic            got_oe_n_out,
  output logic      [7:0] fifo_byte_out
);
  logic wait_r;
  logic cmd_n;

  // ========================================================================
  // Wait line; hold keeps the peripheral not ready so a 1.9 port must wait
  assign cmd_n = data_strobe_n_in & addr_strobe_n_in;
  assign peripheral_wait_n_out = wait_r | hold_wait_in;

  // EPP side: snapshot the cable at strobe, drive the read byte after delay_in cycles and raise wait one cycle later
  initial
  begin
    wait_r = 1'b0;
    drive_data_out = 8'hA5;
    forever
    begin
      @(negedge cmd_n);
      #1;
      got_byte_out = wire_data_in;
      got_addr_out = !addr_strobe_n_in;
      got_dir_n_out = transfer_direction_n_in;
      got_oe_n_out = cable_data_oe_n_in;
      if (!mute_in)
      begin
        repeat (delay_in) @(negedge clock_in);
        drive_data_out = read_byte_in;
        @(negedge clock_in);
        wait_r = 1'b1;
        @(posedge cmd_n);
        @(negedge clock_in);
        // Released lines show the inverse, never a stale copy
        drive_data_out = ~read_byte_in;
        wait_r = 1'b0;
      end
    end
  end

  // FIFO side: busy follows the forward strobe after delay_in cycles
  initial
  begin
    peripheral_busy_out = 1'b0;
    fifo_byte_out = 8'h00;
    forever
    begin
      @(negedge host_strobe_n_in);
      #1;
      fifo_byte_out = wire_data_in;
      repeat (delay_in) @(negedge clock_in);
      peripheral_busy_out = 1'b1;
      @(posedge host_strobe_n_in);
      repeat (delay_in) @(negedge clock_in);
      peripheral_busy_out = 1'b0;
    end
  end
endmodule
`default_nettype wire

// >>> tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin check_count++; if ((got) !== (ex)) begin n_errors++; \
  $display("CHECK FAILED %s expected %h seen %h", nm, ex, got); end end
// ==========================================================================
// Self-checking bench for the parallel port handshake block
module tb;
  import epp_pkg::*;
  logic       clock_in, rst_n_in, req, wr, ad, v19, dir_bit, clr, ack;
  logic [2:0] mode;
  logic [7:0] hdin, hdout, dma_data, cab_out, cab_wire, rd_byte, dly, drv, got_b, fifo_b;
  logic       rdy, flag, dma_req, oe_n, dir_n, dstb_n, astb_n, hstb_n, wait_n, busy;
  logic       mute, hold, got_a, got_dir, got_oe;
  int         n_errors, check_count;

  // Cable wire: whoever has the drivers enabled sets the level
  assign cab_wire = oe_n ? drv : cab_out;

  epp_parallel_port_handshake uut (.clock_in(clock_in), .rst_n_in(rst_n_in),
    .host_req_in(req), .host_write_in(wr), .host_addr_cycle_in(ad),
    .host_system_data_in(hdin), .host_system_data_out(hdout), .chan_ready_out(rdy),
    .port_mode_in(mode), .epp_v19_in(v19), .port_direction_bit_in(dir_bit),
    .timeout_clr_in(clr), .timeout_flag_out(flag), .dma_req_out(dma_req),
    .dma_ack_in(ack), .dma_data_in(dma_data), .cable_data_lines_in(cab_wire),
    .cable_data_lines_out(cab_out), .cable_data_oe_n_out(oe_n),
    .transfer_direction_n_out(dir_n), .data_strobe_n_out(dstb_n),
    .addr_strobe_n_out(astb_n), .host_strobe_n_out(hstb_n),
    .peripheral_wait_n_in(wait_n), .peripheral_busy_in(busy));

  epp_periph_model partner (.clock_in(clock_in), .data_strobe_n_in(dstb_n),
    .addr_strobe_n_in(astb_n), .host_strobe_n_in(hstb_n),
    .transfer_direction_n_in(dir_n), .cable_data_oe_n_in(oe_n), .wire_data_in(cab_wire),
    .read_byte_in(rd_byte), .delay_in(dly), .mute_in(mute), .hold_wait_in(hold),
    .peripheral_wait_n_out(wait_n), .peripheral_busy_out(busy), .drive_data_out(drv),
    .got_byte_out(got_b), .got_addr_out(got_a), .got_dir_n_out(got_dir),
    .got_oe_n_out(got_oe), .fifo_byte_out(fifo_b));

  // ========================================================================
  // Verdict; also the landing place of any exhausted wait
  task automatic close_out();
    if (n_errors == 0 && check_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // Waits up to lim falling edges for ready; returns cycles used
  task automatic wait_ready(input int lim, output int n, output int quiet);
    n = 0;
    quiet = 0;
    while (rdy !== 1'b1)
    begin
      @(negedge clock_in);
      quiet = (wait_n === 1'b1) ? quiet + 1 : 0;
      n++;
      if (n > lim)
      begin
        n_errors++;
        close_out();
      end
    end
  endtask

  // One EPP byte cycle, judged from the cable snapshot and host outputs
  task automatic epp_cycle(input logic w, input logic a, input logic v,
                           input logic [7:0] b, input logic [7:0] d, input logic h);
    int n;
    int quiet;
    @(negedge clock_in);
    {wr, ad, v19, dir_bit, hdin, rd_byte, dly, hold} = {w, a, v, !w, b, ~b, d, h};
    // A held-off wait line must get through the filter before the request
    repeat (h ? 10 : 1) @(negedge clock_in);
    req = 1'b1;
    #1;
    `CHK("ready_in_request", 1'b0, rdy)
    if (h)
    begin
      repeat (40) @(negedge clock_in);
      `CHK("strobe_held_back", 1'b1, dstb_n & astb_n)
      hold = 1'b0;
    end
    wait_ready(1200, n, quiet);
    `CHK("wait_settled", 1'b1, quiet >= SETTLE_CYC)
    `CHK("strobe_released", 1'b1, dstb_n & astb_n)
    `CHK("dir_at_strobe", !w, got_dir)
    `CHK("float_at_strobe", !w, got_oe)
    `CHK("strobe_kind", a, got_a)
    if (w)
      `CHK("write_byte", b, got_b)
    else
      `CHK("read_byte", ~b, hdout)
    req = 1'b0;
    // Filtered wait must show the reasserted level before a 1.7 strobe
    repeat (10) @(negedge clock_in);
    `CHK("dir_idle", v ? 1'b1 : dir_bit, dir_n)
  endtask

  // Silent peripheral: the port must abort and flag it
  task automatic timeout_case();
    int n;
    int quiet;
    mute = 1'b1;
    @(negedge clock_in);
    // 1.7 write: software clears the direction bit first
    {wr, v19, dir_bit} = 3'b100;
    req = 1'b1;
    #1;
    wait_ready(1200, n, quiet);
    `CHK("abort_late_enough", 1'b1, n >= TOUT_CYC)
    `CHK("abort_flag", 1'b1, flag)
    `CHK("abort_strobe", 1'b1, dstb_n & astb_n)
    req = 1'b0;
    mute = 1'b0;
    clr = 1'b1;
    @(negedge clock_in);
    clr = 1'b0;
    @(negedge clock_in);
    `CHK("flag_cleared", 1'b0, flag)
  endtask

  // FIFO mode refuses EPP requests, so channel ready stays high
  task automatic fifo_enter();
    mode = MODE_FIFO;
    dly = 8'h3C;
    req = 1'b1;
    repeat (4) @(negedge clock_in);
    `CHK("fifo_ignores_epp", 1'b1, rdy)
    req = 1'b0;
  endtask

  // Forward FIFO bytes fed by DMA and paced by a slow busy line
  task automatic fifo_case(input logic [7:0] b);
    int n;
    n = 0;
    while (dma_req !== 1'b1)
    begin
      @(negedge clock_in);
      if (++n > 500)
      begin
        n_errors++;
        close_out();
      end
    end
    ack = 1'b1;
    dma_data = b;
    @(negedge clock_in);
    ack = 1'b0;
    n = 0;
    while (hstb_n !== 1'b1 || n == 0)
    begin
      @(negedge clock_in);
      n = (hstb_n === 1'b0) ? n + 1 : n;
      if (n > 500)
      begin
        n_errors++;
        close_out();
      end
    end
    `CHK("fifo_strobe_width", 1'b1, n >= FIFO_STB_CYC)
    `CHK("fifo_byte", b, fifo_b)
    `CHK("fifo_busy_paced", 1'b0, dma_req)
    `CHK("fifo_data_held", b, cab_out)
  endtask

  // ========================================================================
  // 100 MHz clock
  initial
  begin
    clock_in = 1'b0;
    forever #5 clock_in = ~clock_in;
  end

  // Main sequence
  initial
  begin
    n_errors = 0;
    check_count = 0;
    {rst_n_in, req, wr, ad, v19, dir_bit, clr, ack, mute, hold} = '0;
    {mode, hdin, dma_data, rd_byte, dly} = '0;
    repeat (6) @(negedge clock_in);
    `CHK("reset_outputs", 7'h7F, {dstb_n, astb_n, hstb_n, dir_n, oe_n, rdy, !flag})
    rst_n_in = 1'b1;
    // The wait filter leaves reset showing done; let it see the idle line
    repeat (10) @(negedge clock_in);
    for (int i = 0; i < 8; i++)
      epp_cycle(i[0], i[1], i[2], 8'h3C ^ 8'(i * 17), i[0] ? 8'h00 : 8'h14, 1'b0);
    epp_cycle(1'b1, 1'b0, 1'b1, 8'hFF, 8'h03, 1'b1);
    epp_cycle(1'b0, 1'b1, 1'b1, 8'h00, 8'h00, 1'b0);
    timeout_case();
    epp_cycle(1'b1, 1'b1, 1'b0, 8'h81, 8'h02, 1'b0);
    fifo_enter();
    fifo_case(8'h5A);
    fifo_case(8'hC3);
    close_out();
  end
endmodule
`default_nettype wire
